// ### rtl/uart_apb_port.sv
// apb slave register port of the uart: widths, stalls, strobes, privilege
`timescale 1ns/1ns
`default_nettype none
`include "uart_apb_port_consts.svh"

module uart_apb_port
#(
    parameter int DATA_W = 32,
    parameter bit ERR_EN = 1'b0,
    parameter int TMO_W = `TMO_WIDTH_DEF
)
(
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [DATA_W/8-1:0] i_pstrb,
    input wire logic [2:0] i_pprot,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // register file read data for the address on i_paddr
    input wire logic [31:0] i_reg_rdata,
    // fifo status and configuration
    input wire logic i_fifo_en,
    input wire logic i_rx_empty,
    input wire logic i_tx_full,
    input wire logic i_fifo_access_mode,
    input wire logic [2:0] i_prot_level,
    input wire logic [`TMO_CNT_W-1:0] i_timeout_value,
    // committed accesses
    output uart_apb_port_pkg::wr_cmd_t o_wr_cmd,
    output logic o_wr_en,
    output uart_apb_port_pkg::rd_cmd_t o_rd_cmd,
    output logic o_rd_en,
    output logic [`RFW_DATA_W-1:0] o_rfw_data,
    output logic o_rfw_push
);

    localparam int NB = DATA_W / 8;
    localparam logic [1:0] LANE_ALIGN = 2'(~(NB - 1));

    // ==========================================================
    // helpers
    // ==========================================================

    // significant bits of the register at a byte offset
    function automatic logic [31:0] reg_mask(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        if (w == `OFS_RX_TX || w == `OFS_LINE_STAT)
            reg_mask = `MASK_DATA9;
        else if (w >= `OFS_SHADOW_LO && w <= `OFS_SHADOW_HI)
            reg_mask = `MASK_DATA9;
        else if (w == `OFS_RX_FIFO_WR)
            reg_mask = `MASK_RFW;
        else if (w == `OFS_TX_LEVEL || w == `OFS_RX_LEVEL)
            reg_mask = `MASK_LEVEL;
        else if (w == `OFS_DE_TIMING || w == `OFS_TA_TIMING)
            reg_mask = `MASK_TIMING;
        else if (w == `OFS_DIV_FRAC)
            reg_mask = `MASK_FRAC;
        else if (w == `OFS_PARAM || w == `OFS_VERSION || w == `OFS_TYPE)
            reg_mask = `MASK_WORD;
        else
            reg_mask = `MASK_BYTE;
    endfunction

    // first byte lane of the word that the current bus beat covers
    function automatic logic [1:0] lane_base(input logic [7:0] a);
        lane_base = a[1:0] & LANE_ALIGN;
    endfunction

    // registers guarded by the privilege level
    function automatic logic is_protected(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        is_protected = (w == `OFS_RX_TX) || (w == `OFS_FIFO_CTRL) ||
                       (w == `OFS_LINE_CTRL) || (w == `OFS_MODEM_CTRL);
    endfunction

    // ==========================================================
    // reset release
    // ==========================================================

    logic rst_meta_r;
    logic rst_n_r;

    // assert at once, release after two edges
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // access decode
    // ==========================================================

    logic setup;
    logic is_data_reg;
    logic stall_now;
    logic priv_err;
    logic [31:0] wdata_word;
    logic [3:0] be_word;
    logic [31:0] rdata_masked;
    logic [31:0] rdata_lane;

    uart_apb_port_pkg::port_state_t state_r;
    logic [7:0] addr_r;
    logic write_r;
    logic [`TMO_CNT_W-1:0] tmo_cnt_r;
    logic timed_out;

    assign setup = i_psel && !i_penable;
    assign is_data_reg = ({i_paddr[7:2], 2'b00} == `OFS_RX_TX);

    // only receive reads and transmit writes can stall, and only with fifos
    assign stall_now = is_data_reg && i_fifo_en &&
                       (i_pwrite ? i_tx_full : i_rx_empty);

    // three mismatch cases between pprot and the programmed level
    assign priv_err = ERR_EN && is_protected(i_paddr) &&
        ((!i_pprot[`PROT_PRIV] && i_prot_level[`PROT_PRIV]) ||
         (i_pprot[`PROT_NSEC] && !i_prot_level[`PROT_NSEC]) ||
         (!i_pprot[`PROT_INSTR] && i_pprot[`PROT_PRIV] &&
          i_prot_level[`PROT_INSTR]));

    // place the bus beat on its lanes of the 32-bit register word
    assign wdata_word = {(32 / DATA_W){i_pwdata}};
    assign be_word = 4'(i_pstrb) << lane_base(i_paddr);

    // zero above register width, then pick the lanes of this beat
    assign rdata_masked = i_reg_rdata & reg_mask(i_paddr);
    assign rdata_lane = rdata_masked >> {lane_base(i_paddr), 3'b000};

    // timeout: width 0 fires at once, else the count once stalled;
    // the counter still holds the last stall's length until a setup
    assign timed_out = ERR_EN && ((TMO_W == 0) ||
        (state_r == uart_apb_port_pkg::ST_STALL &&
         tmo_cnt_r >= i_timeout_value));

    // ==========================================================
    // handshake state
    // ==========================================================

    // stall state keeps the latched address; ends on data or timeout
    always_ff @(posedge i_sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= uart_apb_port_pkg::ST_IDLE;
            addr_r <= 8'h00;
            write_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            case (state_r)
                uart_apb_port_pkg::ST_IDLE:
                begin
                    if (setup)
                    begin
                        addr_r <= i_paddr;
                        write_r <= i_pwrite;
                        if (stall_now && !priv_err && !timed_out)
                            state_r <= uart_apb_port_pkg::ST_STALL;
                        else
                            state_r <= uart_apb_port_pkg::ST_DONE;
                    end
                end
                uart_apb_port_pkg::ST_STALL:
                begin
                    if (!stall_now || timed_out)
                        state_r <= uart_apb_port_pkg::ST_DONE;
                end
                uart_apb_port_pkg::ST_DONE:
                begin
                    state_r <= uart_apb_port_pkg::ST_IDLE;
                end
                default:
                begin
                    state_r <= uart_apb_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // stall length counter; restarts at 1 at every setup
    always_ff @(posedge i_sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            tmo_cnt_r <= '0;
        else if (i_clk_en)
        begin
            if (setup && state_r == uart_apb_port_pkg::ST_IDLE)
                tmo_cnt_r <= `TMO_CNT_W'(1);
            else if (state_r == uart_apb_port_pkg::ST_STALL &&
                     !tmo_cnt_r[`TMO_CNT_W-1])
                tmo_cnt_r <= tmo_cnt_r + `TMO_CNT_W'(1);
        end
    end

    // ==========================================================
    // apb answer
    // ==========================================================

    logic finish;
    logic fail;

    // finish: the transfer completes in the next cycle
    always_comb
    begin
        finish = 1'b0;
        fail = 1'b0;
        if (state_r == uart_apb_port_pkg::ST_IDLE && setup)
        begin
            finish = !stall_now || priv_err || timed_out;
            fail = priv_err || (stall_now && timed_out);
        end
        else if (state_r == uart_apb_port_pkg::ST_STALL)
        begin
            finish = !stall_now || timed_out;
            fail = stall_now && timed_out;
        end
    end

    // pready idles high so unstalled accesses need no wait state
    always_ff @(posedge i_sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_pready <= 1'b1;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end
        else if (i_clk_en)
        begin
            if (finish)
            begin
                o_pready <= 1'b1;
                o_pslverr <= fail;
                o_prdata <= fail ? '0 : rdata_lane[DATA_W-1:0];
            end
            else if (setup || state_r == uart_apb_port_pkg::ST_STALL)
            begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // committed effects
    // ==========================================================

    // strobes only on a good finish; errors leave fifos and registers alone
    always_ff @(posedge i_sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_wr_en <= 1'b0;
            o_rd_en <= 1'b0;
            o_wr_cmd <= '0;
            o_rd_cmd <= '0;
        end
        else if (i_clk_en)
        begin
            o_wr_en <= finish && !fail && i_pwrite;
            o_rd_en <= finish && !fail && !i_pwrite;
            if (finish && !fail)
            begin
                o_wr_cmd.addr <= i_paddr;
                o_wr_cmd.data <= wdata_word;
                o_wr_cmd.be <= i_pwrite ? be_word : 4'h0;
                o_rd_cmd.addr <= i_paddr;
            end
        end
    end

    logic rfw_hit;
    logic [`RFW_DATA_W-1:0] rfw_r;
    logic [`RFW_DATA_W-1:0] rfw_nxt;

    assign rfw_hit = finish && !fail && i_pwrite &&
                     ({i_paddr[7:2], 2'b00} == `OFS_RX_FIFO_WR);

    // merge strobed lanes into the held data field
    always_comb
    begin
        rfw_nxt = rfw_r;
        if (be_word[0])
            rfw_nxt[7:0] = wdata_word[7:0];
        if (be_word[1])
            rfw_nxt[`RFW_DATA_MSB] = wdata_word[`RFW_DATA_MSB];
    end

    // the 8-bit bus fills the field over two beats; lane 1 triggers the push
    always_ff @(posedge i_sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rfw_r <= '0;
            o_rfw_data <= '0;
            o_rfw_push <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_rfw_push <= 1'b0;
            if (rfw_hit)
            begin
                rfw_r <= rfw_nxt;
                if (i_fifo_access_mode && be_word[1])
                begin
                    o_rfw_data <= rfw_nxt;
                    o_rfw_push <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ### rtl/uart_apb_port_consts.svh
// offsets, field positions, reset values and timing counts of the apb port
// Contract
// - apb data bus width is 8, 16 or 32 bits, chosen at build time
// - registers are byte addressed; ordinary registers fit one 8-bit transfer
// - wider registers up to 32 bits need several transfers on narrow buses
// - read data bits above the addressed register width read as zero
// - pready stays high except receive/transmit accesses with fifos enabled
// - receive read on empty fifo stalls until a character arrives
// - transmit write on full fifo stalls until a character leaves
// - stall reaching the programmed timeout period ends with pslverr
// - pslverr and privilege checks exist only with the error option built
// - apb4 writes update only bytes whose strobe bit is high
// - strobe bit n qualifies write data bits 8n+7 down to 8n
// - in fifo access mode receive-fifo-write data is pushed to receive path
// - on 8-bit bus push happens only on the write strobing byte lane 1
// - protected register access without privilege errors, register unchanged
// - error when pprot/level mismatch in any of the three listed cases
// - timeout counter width 0 or 4 to 8; zero times out at once
`ifndef UART_APB_PORT_CONSTS_SVH
`define UART_APB_PORT_CONSTS_SVH

// register byte offsets
`define OFS_RX_TX 8'h00
`define OFS_FIFO_CTRL 8'h08
`define OFS_LINE_CTRL 8'h0C
`define OFS_MODEM_CTRL 8'h10
`define OFS_LINE_STAT 8'h14
`define OFS_SHADOW_LO 8'h30
`define OFS_SHADOW_HI 8'h6C
`define OFS_RX_FIFO_WR 8'h78
`define OFS_TX_LEVEL 8'h80
`define OFS_RX_LEVEL 8'h84
`define OFS_DE_TIMING 8'hB0
`define OFS_TA_TIMING 8'hB4
`define OFS_DIV_FRAC 8'hC0
`define OFS_PARAM 8'hF4
`define OFS_VERSION 8'hF8
`define OFS_TYPE 8'hFC

// significant bits of each register
`define MASK_BYTE 32'h0000_00FF
`define MASK_DATA9 32'h0000_01FF
`define MASK_RFW 32'h0000_03FF
`define MASK_LEVEL 32'h0000_01FF
`define MASK_TIMING 32'h00FF_00FF
`define MASK_FRAC 32'h0000_000F
`define MASK_WORD 32'hFFFF_FFFF

// receive-fifo-write data field
`define RFW_DATA_MSB 8
`define RFW_DATA_W 9

// privilege level bits
`define PROT_PRIV 0
`define PROT_NSEC 1
`define PROT_INSTR 2
`define PROT_LEVEL_RST 3'h2

// timeout counter
`define TMO_CNT_W 9
`define TMO_WIDTH_DEF 4

`endif

// ### rtl/uart_apb_port_pkg.sv
// types shared by the uart apb register port
package uart_apb_port_pkg;

    // access handshake states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STALL = 2'b01,
        ST_DONE = 2'b10
    } port_state_t;

    // write committed toward the register file, byte lanes of a 32-bit word
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] be;
    } wr_cmd_t;

    // read committed toward the register file (pops on the receive buffer)
    typedef struct packed {
        logic [7:0] addr;
    } rd_cmd_t;

endpackage

// ### testbench/uart_apb_port_checker.sv
// concurrent checks of the uart apb port at its pins
`timescale 1ns/1ns
`default_nettype none
`include "uart_apb_port_consts.svh"

module uart_apb_port_checker
#(
    parameter int DATA_W = 32,
    parameter bit ERR_EN = 1'b0,
    parameter int TMO_W = 4
)
(
    // clock and apb
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [DATA_W/8-1:0] i_pstrb,
    input wire logic [2:0] i_pprot,
    input wire logic [DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // status and commits
    input wire logic i_fifo_en,
    input wire logic i_rx_empty,
    input wire logic i_fifo_access_mode,
    input wire logic [2:0] i_prot_level,
    input wire logic [`TMO_CNT_W-1:0] i_timeout_value,
    input wire uart_apb_port_pkg::wr_cmd_t o_wr_cmd,
    input wire logic o_wr_en,
    input wire logic o_rd_en,
    input wire logic o_rfw_push
);
    logic setup;
    logic prot_bad;
    logic fifo_reg;
    logic [8:0] stall_cnt_r;

    // ==========================================================
    // helpers
    assign setup = i_psel && !i_penable;
    assign fifo_reg = i_fifo_en && i_paddr == 8'h00;
    assign prot_bad = ERR_EN && (i_paddr inside {8'h00, 8'h08, 8'h0C, 8'h10})
        && ((!i_pprot[0] && i_prot_level[0]) || (i_pprot[1] && !i_prot_level[1])
        || (!i_pprot[2] && i_pprot[0] && i_prot_level[2]));

    // wait states so far; a counter, since the timeout can exceed 8
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            stall_cnt_r <= 9'h000;
        else if (o_pready)
            stall_cnt_r <= 9'h000;
        else
            stall_cnt_r <= stall_cnt_r + 9'h001;
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    // ==========================================================
    // assertions
    idle_ready_a: assert property (!i_psel |-> o_pready)
        else $error("ready low outside a transfer");
    no_stall_a: assert property (setup && !fifo_reg |=> o_pready)
        else $error("stall on a register that never waits");
    rx_stall_a: assert property (setup && !prot_bad && fifo_reg
        && i_rx_empty && !i_pwrite && TMO_W != 0
        && i_timeout_value > 9'h001 |=> !o_pready)
        else $error("empty receive read not held");
    prot_err_a: assert property (setup && prot_bad |=> o_pready
        && o_pslverr && !o_wr_en && !o_rd_en)
        else $error("privilege miss not refused");
    clean_ok_a: assert property (setup && !prot_bad && !fifo_reg
        |=> !o_pslverr)
        else $error("error without cause");
    strobe_lane_a: assert property (o_wr_en
        |-> o_wr_cmd.be == 4'(i_pstrb))
        else $error("byte enables differ from strobes");
    lane_push_a: assert property (o_rfw_push
        |-> i_pstrb[1] && i_paddr == 8'h78 && i_fifo_access_mode)
        else $error("receive push without lane 1 write");
    err_commit_a: assert property (o_pslverr && o_pready && i_penable
        |-> !o_wr_en && !o_rd_en && !o_rfw_push)
        else $error("commit on an errored transfer");
    tmo_bound_a: assert property (ERR_EN && TMO_W != 0 && !o_pready
        |-> stall_cnt_r < i_timeout_value)
        else $error("stall outlived its timeout");
    zero_pad_a: assert property (o_pready && i_penable && !i_pwrite
        && i_paddr == 8'h14 |-> (o_prdata >> 9) == '0)
        else $error("bits above status width not zero");

    // main scenarios reached
    cover property (setup ##1 !o_pready [*3] ##1 o_pready && !o_pslverr);
    cover property (!o_pready ##1 o_pready && o_pslverr);
    cover property (o_rfw_push);
endmodule

bind uart_apb_port uart_apb_port_checker #(.DATA_W(DATA_W), .ERR_EN(ERR_EN),
    .TMO_W(TMO_W)) chk (.i_sys_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pstrb, .i_pprot, .o_prdata, .o_pready, .o_pslverr, .i_fifo_en,
    .i_rx_empty, .i_fifo_access_mode, .i_prot_level, .i_timeout_value,
    .o_wr_cmd, .o_wr_en, .o_rd_en, .o_rfw_push);
`default_nettype wire

// ### testbench/apb_host_model.sv
// behavioural apb master standing in for the host processor
`timescale 1ns/1ns
`default_nettype none

module apb_host_model
(
    // clock
    input wire logic i_sys_clk,
    // apb master side
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    output logic [3:0] o_pstrb,
    output logic [2:0] o_pprot,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    // idle bus from time zero
    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
        o_pstrb = 4'h0;
        o_pprot = 3'h0;
    end

    // one transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic [2:0] p,
        output logic [31:0] rd, output logic er, output int wt);
        wt = 0;
        @(negedge i_sys_clk);
        o_psel = 1'b1;
        o_pwrite = w;
        o_paddr = a;
        o_pwdata = d;
        o_pstrb = w ? s : 4'h0;
        o_pprot = p;
        @(negedge i_sys_clk);
        o_penable = 1'b1;
        @(posedge i_sys_clk);
        // bounded so a lost ready cannot hang the host
        while (i_pready !== 1'b1 && wt < 64)
        begin
            wt++;
            @(posedge i_sys_clk);
        end
        rd = i_prdata;
        er = i_pslverr;
        @(negedge i_sys_clk);
        o_psel = 1'b0;
        o_penable = 1'b0;
        // released lines must not keep showing the last value
        o_paddr = ~a;
        o_pwdata = ~d;
    endtask
endmodule
`default_nettype wire

// ### testbench/uart_apb_port_tb.sv
// self-checking bench of the uart apb register port
`timescale 1ns/1ns
`default_nettype none
`include "uart_apb_port_consts.svh"

module uart_apb_port_tb;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, last_rd;
    logic [31:0] pwdata, prdata, reg_rdata, rd;
    logic [3:0] pstrb;
    logic [2:0] pprot, lvl;
    logic fifo_en, rx_empty, tx_full, fam, wr_en, rd_en, push, er;
    logic [8:0] tmo, rfw_data;
    uart_apb_port_pkg::wr_cmd_t wr_cmd, last_wr;
    uart_apb_port_pkg::rd_cmd_t rd_cmd;
    int failures, n_tests, wt, wr_n, rd_n, push_n, cyc;

    // ==========================================================
    // design, host model and register file stand-in
    uart_apb_port #(.DATA_W(32), .ERR_EN(1'b1), .TMO_W(4)) dut (
        .i_sys_clk(clk), .i_arst_n(arst_n), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_pprot(pprot),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_reg_rdata(reg_rdata), .i_fifo_en(fifo_en), .i_rx_empty(rx_empty),
        .i_tx_full(tx_full), .i_fifo_access_mode(fam), .i_prot_level(lvl),
        .i_timeout_value(tmo), .o_wr_cmd(wr_cmd), .o_wr_en(wr_en),
        .o_rd_cmd(rd_cmd), .o_rd_en(rd_en), .o_rfw_data(rfw_data),
        .o_rfw_push(push));
    apb_host_model m (.i_sys_clk(clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb), .o_pprot(pprot), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));
    assign reg_rdata = {4{paddr}} ^ 32'hA5C3_96F0;

    // clock and commit monitor; a hung run is cut short here
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (wr_en === 1'b1) begin wr_n++; last_wr = wr_cmd; end
        if (rd_en === 1'b1)
        begin
            rd_n++;
            last_rd = rd_cmd.addr;
        end
        if (push === 1'b1) push_n++;
        if (cyc == 3000) begin failures++; tally_and_finish(); end
    end

    // ==========================================================
    // helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task t_width();
        logic [7:0] a[5] = '{8'h0C, 8'h14, 8'hB0, 8'hC0, 8'hFC};
        logic [31:0] k[5] = '{`MASK_BYTE, `MASK_DATA9, `MASK_TIMING,
            `MASK_FRAC, `MASK_WORD};
        for (int i = 0; i < 5; i++)
        begin
            m.xfer(1'b0, a[i], 32'h0, 4'h0, 3'h2, rd, er, wt);
            chk("rdata", ({4{a[i]}} ^ 32'hA5C3_96F0) & k[i], rd);
            chk("wait", 32'h0, 32'(wt));
        end
    endtask
    task t_strobe();
        for (int i = 0; i < 4; i++)
        begin
            m.xfer(1'b1, 8'hB0, 32'h1122_3344, 4'h1 << i, 3'h2, rd, er, wt);
            chk("be", 32'h1 << i, 32'(last_wr.be));
            chk("wdata", 32'h1122_3344, last_wr.data);
            chk("wr addr", 32'hB0, 32'(last_wr.addr));
            chk("wr count", 32'(i + 1), 32'(wr_n));
        end
    endtask
    task t_prot();
        logic [2:0] p[3] = '{3'h0, 3'h3, 3'h1};
        logic [2:0] l[3] = '{3'h1, 3'h0, 3'h4};
        for (int i = 0; i < 3; i++)
        begin
            lvl = l[i];
            m.xfer(1'b1, 8'h0C, 32'h55, 4'hF, p[i], rd, er, wt);
            chk("prot err", 32'h1, 32'(er));
            chk("wr count", 32'h4, 32'(wr_n));
        end
        m.xfer(1'b1, 8'h14, 32'h55, 4'hF, 3'h0, rd, er, wt);
        chk("open err", 32'h0, 32'(er));
        chk("wr count", 32'h5, 32'(wr_n));
        lvl = 3'h2;
    endtask
    task t_stall(input logic w);
        fifo_en = 1'b1;
        if (w) tx_full = 1'b1; else rx_empty = 1'b1;
        fork
            m.xfer(w, 8'h00, 32'h3C, 4'h1, 3'h2, rd, er, wt);
            begin
                repeat (4) @(negedge clk);
                tx_full = 1'b0;
                rx_empty = 1'b0;
            end
        join
        chk("stalled", 32'h1, 32'(wt > 1));
        chk("stall err", 32'h0, 32'(er));
        chk("commits", 32'h1, 32'(w ? wr_n - 5 : rd_n - 5));
        chk("cmd addr", 32'h0, 32'(w ? last_wr.addr : last_rd));
    endtask
    task t_timeout();
        rx_empty = 1'b1;
        m.xfer(1'b0, 8'h00, 32'h0, 4'h0, 3'h2, rd, er, wt);
        chk("tmo err", 32'h1, 32'(er));
        chk("tmo waits", 32'(tmo), 32'(wt));
        chk("tmo pops", 32'h6, 32'(rd_n));
        fifo_en = 1'b0;
        m.xfer(1'b0, 8'h00, 32'h0, 4'h0, 3'h2, rd, er, wt);
        chk("no fifo wait", 32'h0, 32'(wt));
        rx_empty = 1'b0;
    endtask
    task t_rfw();
        fam = 1'b1;
        m.xfer(1'b1, 8'h78, 32'hA5, 4'h1, 3'h2, rd, er, wt);
        chk("early push", 32'h0, 32'(push_n));
        m.xfer(1'b1, 8'h78, 32'h100, 4'h2, 3'h2, rd, er, wt);
        chk("push", 32'h1, 32'(push_n));
        chk("push data", 32'h1A5, 32'(rfw_data));
    endtask

    // main sequence: two cycles of reset, then the scenarios
    initial
    begin
        arst_n = 1'b0;
        {fifo_en, rx_empty, tx_full, fam} = 4'h0;
        lvl = `PROT_LEVEL_RST;
        tmo = 9'd12;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_width();
        t_strobe();
        t_prot();
        t_stall(1'b0);
        t_stall(1'b1);
        rd_n = 6;
        t_timeout();
        t_rfw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
